/* fsra_regs.svh */
// Register offsets, opcodes, field positions and reset values of the status access block
`ifndef FSRA_REGS_SVH
`define FSRA_REGS_SVH

// ***************************************************
// Status byte addresses for the indirect commands
// ***************************************************
`define FSRA_OFS_SB1 8'h01
`define FSRA_OFS_SB2 8'h02
`define FSRA_OFS_SB3 8'h03
`define FSRA_OFS_SB4 8'h04
`define FSRA_OFS_SB5 8'h05
`define FSRA_OFS_SB6 8'h06

// ***************************************************
// Reset values
// ***************************************************
`define FSRA_SB1_RESET 8'h00
`define FSRA_SB2_RESET 8'h00
`define FSRA_SB3_RESET 8'h00
`define FSRA_SB4_RESET 8'h00
`define FSRA_SB5_RESET 8'h00
`define FSRA_SB6_RESET 8'h00

// ***************************************************
// Fields
// ***************************************************
`define FSRA_WEL_POS 1
`define FSRA_UNDEF_DATA 8'h00

// ***************************************************
// Opcodes
// ***************************************************
`define FSRA_OP_RD_IND 8'h65
`define FSRA_OP_WR_SB1 8'h01
`define FSRA_OP_WR_SB2 8'h31
`define FSRA_OP_WR_SB3 8'h11
`define FSRA_OP_WR_IND 8'h71
`define FSRA_OP_WREN 8'h06
`define FSRA_OP_WREN_VOL 8'h50

// ***************************************************
// Frame layout, in bytes counted from the opcode
// ***************************************************
`define FSRA_BYTE_OPCODE 3'h0
`define FSRA_BYTE_ADDR 3'h1
`define FSRA_BYTE_SECOND 3'h2
`define FSRA_BYTE_RD_DATA 3'h3
`define FSRA_BYTE_MAX 3'h7
`define FSRA_BIT_LAST 3'h7

`endif

/* fsra_pkg.sv */
// Types shared by the status access block
package fsra_pkg;
   typedef logic [5:0][7:0] fsra_stat_t;
   typedef enum logic [1:0] {
      FSRA_ST_IDLE = 2'b00,
      FSRA_ST_COMMIT = 2'b01,
      FSRA_ST_PUBLISH = 2'b11
   } fsra_state_t;
endpackage

/* fsra_link_if.sv */
// Frame result and status snapshot passed between the link and system domains
`timescale 1ns/1ps
`default_nettype none
interface fsra_link_if;
   logic [7:0] op_byte;
   logic [7:0] first_byte;
   logic [7:0] second_byte;
   logic [2:0] byte_cnt;
   logic [2:0] bit_cnt;
   logic start_tgl;
   fsra_pkg::fsra_stat_t snap;
   modport link (
      output op_byte,
      output first_byte,
      output second_byte,
      output byte_cnt,
      output bit_cnt,
      output start_tgl,
      input snap
   );
   modport core (
      input op_byte,
      input first_byte,
      input second_byte,
      input byte_cnt,
      input bit_cnt,
      input start_tgl,
      output snap
   );
endinterface
`default_nettype wire

/* fsra_sync.sv */
// Two-stage level synchroniser into the system clock
`timescale 1ns/1ps
`default_nettype none
module fsra_sync #(
   parameter logic RST_VAL = 1'b1
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic async_in,
   output var logic sync_out
);
   logic meta_reg;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         meta_reg <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule
`default_nettype wire

/* fsra_link.sv */
// Serial link shifter running on the host's serial clock
`include "fsra_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module fsra_link (
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_si,
   output var logic spi_so,
   output var logic spi_so_oe,
   fsra_link_if.link lnk
);
   import fsra_pkg::*;

   logic fresh_reg;
   // The link domain has no reset, so the frame toggle starts from a known
   // level to match the system side's copy after reset.
   logic tgl_reg = 1'b0;
   logic [6:0] shift_reg;
   logic [2:0] bit_reg;
   logic [2:0] byte_reg;
   logic [7:0] op_reg;
   logic [7:0] first_reg;
   logic [7:0] second_reg;
   logic [7:0] rd_addr_reg;
   wire [7:0] rx_byte;
   wire byte_done;
   wire rd_phase;
   wire addr_ok;
   wire [2:0] rd_idx;
   wire [7:0] rd_byte;
   wire [2:0] byte_next;

   assign rx_byte = {shift_reg, spi_si};
   assign byte_done = ~fresh_reg & (bit_reg == `FSRA_BIT_LAST);
   assign byte_next = fresh_reg ? `FSRA_BYTE_OPCODE :
      (byte_done && byte_reg != `FSRA_BYTE_MAX) ? byte_reg + 3'h1 : byte_reg;
   assign rd_phase = ~fresh_reg & (op_reg == `FSRA_OP_RD_IND)
      & (byte_reg >= `FSRA_BYTE_RD_DATA);
   assign addr_ok = (rd_addr_reg >= `FSRA_OFS_SB1) && (rd_addr_reg <= `FSRA_OFS_SB6);
   assign rd_idx = 3'(rd_addr_reg - `FSRA_OFS_SB1);
   // Unimplemented addresses return a fixed filler byte
   assign rd_byte = addr_ok ? lnk.snap[rd_idx] : `FSRA_UNDEF_DATA;

   // ***************************************************
   // Frame start marker
   // ***************************************************
   // The serial clock stops between frames, so select high is the only
   // thing that can rearm the counters for the next frame.
   always_ff @(posedge spi_sck or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         fresh_reg <= 1'b1;
      end else begin
         fresh_reg <= 1'b0;
      end
   end

   // ***************************************************
   // Input shifting, most significant bit first
   // ***************************************************
   always_ff @(posedge spi_sck) begin
      shift_reg <= rx_byte[6:0];
      bit_reg <= fresh_reg ? 3'h1 : bit_reg + 3'h1;
      byte_reg <= byte_next;
      if (fresh_reg) begin
         tgl_reg <= ~tgl_reg;
      end
      if (byte_done && byte_reg == `FSRA_BYTE_OPCODE) begin
         op_reg <= rx_byte;
      end
      if (byte_done && byte_reg == `FSRA_BYTE_ADDR) begin
         first_reg <= rx_byte;
      end
      if (byte_done && byte_reg == `FSRA_BYTE_SECOND) begin
         second_reg <= rx_byte;
      end
      if (byte_done && byte_reg == `FSRA_BYTE_ADDR) begin
         rd_addr_reg <= rx_byte;
      end else if (byte_done && byte_reg >= `FSRA_BYTE_RD_DATA) begin
         // Eight-bit counter wraps from the top address back to zero
         rd_addr_reg <= rd_addr_reg + 8'h01;
      end
   end

   // ***************************************************
   // Output shifting on the falling edge
   // ***************************************************
   always_ff @(negedge spi_sck or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         spi_so_oe <= 1'b0;
         spi_so <= 1'b0;
      end else begin
         spi_so_oe <= rd_phase;
         spi_so <= rd_byte[3'h7 - bit_reg];
      end
   end

   assign lnk.op_byte = op_reg;
   assign lnk.first_byte = first_reg;
   assign lnk.second_byte = second_reg;
   assign lnk.byte_cnt = byte_reg;
   assign lnk.bit_cnt = bit_reg;
   assign lnk.start_tgl = tgl_reg;
endmodule
`default_nettype wire

/* fsra_top.sv */
// Status byte access over the serial link: command decode and status storage
`include "fsra_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module fsra_top (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_si,
   output var logic spi_so,
   output var logic spi_so_oe,
   output var fsra_pkg::fsra_stat_t status_out
);
   import fsra_pkg::*;

   // ***************************************************
   // Declarations
   // ***************************************************
   fsra_link_if lnk ();
   fsra_state_t state_reg;
   fsra_state_t state_next;
   fsra_stat_t stat_reg;
   fsra_stat_t stat_wr;
   fsra_stat_t stat_next;
   fsra_stat_t snap_reg;
   fsra_stat_t stat_reset;
   logic vol_en_reg;
   logic vol_en_next;
   logic seen_tgl_reg;
   logic cs_sync;
   logic cs_high_reg;
   wire frame_end;
   wire frame_new;
   wire aligned;
   wire [7:0] op;
   wire [2:0] n_bytes;
   wire is_dir;
   wire is_ind;
   wire is_wr;
   wire enabled;
   wire dir_ok;
   wire ind_full;
   wire ind_addr_ok;
   wire ind_ok;
   wire commit_wr;
   wire wel_clear;
   wire wren_set;
   wire vol_set;
   wire vol_use;
   wire wel_next;
   wire [5:0] wr_hit;

   // ***************************************************
   // Link domain
   // ***************************************************
   fsra_link u_link (
      .spi_sck(spi_sck),
      .spi_cs_n(spi_cs_n),
      .spi_si(spi_si),
      .spi_so(spi_so),
      .spi_so_oe(spi_so_oe),
      .lnk(lnk.link)
   );

   // Only the select level crosses as a live signal; the frame bytes are
   // frozen once the serial clock stops, so they are read only after the
   // synchronised select has been seen high.
   fsra_sync #(
      .RST_VAL(1'b1)
   ) u_cs_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .async_in(spi_cs_n),
      .sync_out(cs_sync)
   );

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cs_high_reg <= 1'b1;
      end else begin
         cs_high_reg <= cs_sync;
      end
   end

   assign frame_end = cs_sync & ~cs_high_reg;
   // A select pulse with no clock edges leaves the toggle unchanged
   assign frame_new = lnk.start_tgl != seen_tgl_reg;

   // ***************************************************
   // Frame decode
   // ***************************************************
   assign op = lnk.op_byte;
   assign n_bytes = lnk.byte_cnt;
   assign aligned = frame_new & (lnk.bit_cnt == 3'h0);
   assign is_dir = (op == `FSRA_OP_WR_SB1) | (op == `FSRA_OP_WR_SB2)
      | (op == `FSRA_OP_WR_SB3);
   assign is_ind = op == `FSRA_OP_WR_IND;
   assign is_wr = is_dir | is_ind;
   // Either enable grants the write; one copy of each byte is kept
   assign enabled = stat_reg[0][`FSRA_WEL_POS] | vol_en_reg;
   // Short frames never reach the data byte and so leave the status bytes alone
   assign dir_ok = is_dir & aligned & ((n_bytes == `FSRA_BYTE_SECOND)
      | ((op == `FSRA_OP_WR_SB1) & (n_bytes == `FSRA_BYTE_RD_DATA)));
   assign ind_full = is_ind & aligned & (n_bytes == `FSRA_BYTE_RD_DATA);
   assign ind_addr_ok = (lnk.first_byte >= `FSRA_OFS_SB1)
      && (lnk.first_byte <= `FSRA_OFS_SB6);
   assign ind_ok = ind_full & ind_addr_ok;
   assign commit_wr = enabled & (dir_ok | ind_ok);
   assign wel_clear = enabled & (dir_ok | ind_full);
   assign wren_set = aligned & (op == `FSRA_OP_WREN)
      & (n_bytes == `FSRA_BYTE_ADDR);
   assign vol_set = aligned & (op == `FSRA_OP_WREN_VOL)
      & (n_bytes == `FSRA_BYTE_ADDR);
   // The volatile grant is spent by the next status write frame
   assign vol_use = aligned & is_wr;

   // ***************************************************
   // Per-byte write selection
   // ***************************************************
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi = gi + 1) begin : g_byte
         wire dir_hit;
         wire ind_hit;
         wire [7:0] wr_data;
         assign dir_hit = ((op == `FSRA_OP_WR_SB1) && gi == 0)
            || ((op == `FSRA_OP_WR_SB1) && gi == 1
               && n_bytes == `FSRA_BYTE_RD_DATA)
            || ((op == `FSRA_OP_WR_SB2) && gi == 1)
            || ((op == `FSRA_OP_WR_SB3) && gi == 2);
         assign ind_hit = lnk.first_byte == 8'(gi + 1);
         assign wr_hit[gi] = commit_wr & (is_dir ? dir_hit : ind_hit);
         // Byte-one opcode carries status byte two in its second data byte
         assign wr_data = (is_dir && !((op == `FSRA_OP_WR_SB1) && gi == 1))
            ? lnk.first_byte : lnk.second_byte;
         assign stat_wr[gi] = wr_hit[gi] ? wr_data : stat_reg[gi];
      end
   endgenerate

   // Hardware ownership of the latch overrides any data written to it
   assign wel_next = wel_clear ? 1'b0 : wren_set ? 1'b1
      : stat_wr[0][`FSRA_WEL_POS];

   always_comb begin
      stat_next = stat_wr;
      stat_next[0][`FSRA_WEL_POS] = wel_next;
   end

   assign vol_en_next = vol_set ? 1'b1 : vol_use ? 1'b0 : vol_en_reg;

   assign stat_reset = {`FSRA_SB6_RESET, `FSRA_SB5_RESET, `FSRA_SB4_RESET,
      `FSRA_SB3_RESET, `FSRA_SB2_RESET, `FSRA_SB1_RESET};

   // ***************************************************
   // Commit sequencer
   // ***************************************************
   always_comb begin
      case (state_reg)
         FSRA_ST_IDLE: begin
            state_next = frame_end ? FSRA_ST_COMMIT : FSRA_ST_IDLE;
         end
         FSRA_ST_COMMIT: begin
            state_next = FSRA_ST_PUBLISH;
         end
         default: begin
            state_next = FSRA_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg <= FSRA_ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ***************************************************
   // Status storage
   // ***************************************************
   // Changes land only after select has risen, never during a frame
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         stat_reg <= stat_reset;
         vol_en_reg <= 1'b0;
         seen_tgl_reg <= 1'b0;
      end else if (state_reg == FSRA_ST_COMMIT) begin
         stat_reg <= stat_next;
         vol_en_reg <= vol_en_next;
         seen_tgl_reg <= lnk.start_tgl;
      end
   end

   // The link reads this copy while a frame runs; it is refreshed only
   // after a commit, so the host must hold select high long enough for it
   // to settle before starting the next frame.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         snap_reg <= stat_reset;
         status_out <= stat_reset;
      end else if (state_reg == FSRA_ST_PUBLISH) begin
         snap_reg <= stat_reg;
         status_out <= stat_reg;
      end
   end

   assign lnk.snap = snap_reg;
endmodule
`default_nettype wire

/* fsra_top_assertions.sv */
// Port-level concurrent checks for the status access block
`timescale 1ns/1ps
`default_nettype none
module fsra_top_assertions (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_si,
   input wire logic spi_so,
   input wire logic spi_so_oe,
   input wire fsra_pkg::fsra_stat_t status_out
);
   import fsra_pkg::*;
   // ****
   // Frame tracking in the link domain
   // ****
   logic [15:0] cnt_reg;
   logic [15:0] sh_reg;
   always_ff @(posedge spi_sck or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         cnt_reg <= 16'h0000;
         sh_reg <= 16'h0000;
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
         if (cnt_reg < 16'h0010) begin
            sh_reg <= {sh_reg[14:0], spi_si};
         end
      end
   end
   wire logic is_rd = (sh_reg[15:8] == 8'h65) && (cnt_reg >= 16'h0018);
   wire logic [15:0] n_off = cnt_reg - 16'h0018;
   // Eight-bit sum, so the address wraps past the top by itself
   wire logic [7:0] idx = sh_reg[7:0] + n_off[10:3];
   wire logic [7:0] sel = idx - 8'h01;
   wire logic exp_bit = (idx != 8'h00 && idx < 8'h07) ?
      status_out[sel[2:0]][3'h7 - n_off[2:0]] : 1'b0;
   // ****
   // Checks
   // ****
   early_out_a: assert property (@(posedge spi_sck) disable iff (spi_cs_n)
      cnt_reg < 16'h0018 |-> !spi_so_oe) else $error("output enabled before clock 24");
   read_drive_a: assert property (@(posedge spi_sck) disable iff (spi_cs_n)
      is_rd |-> spi_so_oe) else $error("read data not driven");
   read_data_a: assert property (@(posedge spi_sck) disable iff (spi_cs_n)
      is_rd |-> spi_so == exp_bit) else $error("read bit differs from status");
   other_quiet_a: assert property (@(posedge spi_sck) disable iff (spi_cs_n)
      cnt_reg >= 16'h0018 && !is_rd |-> !spi_so_oe) else $error("output driven outside read");
   cs_float_a: assert property (@(posedge clk_sys) disable iff (rst)
      spi_cs_n |-> !spi_so_oe) else $error("output driven while deselected");
   frame_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      !spi_cs_n |=> $stable(status_out)) else $error("status changed inside a frame");
   late_commit_a: assert property (@(posedge clk_sys) disable iff (rst)
      !$stable(status_out) |-> spi_cs_n && $past(spi_cs_n, 3))
      else $error("status changed too soon after release");
   reset_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
      $fell(rst) |-> status_out == 48'h0) else $error("status not cleared by reset");
endmodule
bind fsra_top fsra_top_assertions chk (.clk_sys(clk_sys), .rst(rst), .spi_sck(spi_sck),
   .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so), .spi_so_oe(spi_so_oe),
   .status_out(status_out));
`default_nettype wire

/* fsra_host_model.sv */
// Host controller model that shifts command frames over the serial link
`timescale 1ns/1ps
`default_nettype none
module fsra_host_model (
   output var logic spi_sck,
   output var logic spi_cs_n,
   output var logic spi_si,
   input wire logic spi_so,
   input wire logic spi_so_oe
);
   logic [7:0] rx[$];
   // Non-blocking so edge-triggered processes all see the first idle level
   initial begin
      spi_sck <= 1'b0;
      spi_cs_n <= 1'b1;
      spi_si <= 1'b0;
   end
   // ****
   // Frame: clock stands low between frames, 12 ns period within
   // ****
   task automatic xfer(input logic [7:0] tx[$], input int nbits, input int nrd);
      int i;
      logic [7:0] b;
      rx.delete();
      b = 8'h00;
      spi_cs_n = 1'b0;
      for (i = 0; i < nbits + nrd * 8; i++) begin
         if (i < nbits) spi_si = tx[i / 8][7 - i % 8];
         else spi_si = ~spi_si;
         #6 spi_sck = 1'b1;
         if (i >= nbits) begin
            b = {b[6:0], spi_so};
            if (i % 8 == 7) rx.push_back(b);
         end
         #6 spi_sck = 1'b0;
      end
      #6 spi_cs_n = 1'b1;
      spi_si = ~spi_si;
   endtask
endmodule
`default_nettype wire

/* fsra_top_tb.sv */
// Self-checking bench for the status access block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin fails++; \
   $display("FAIL %s expected %h seen %h", nm, e, s); end end
module fsra_top_tb;
   import fsra_pkg::*;
   logic clk_sys;
   logic rst;
   logic spi_sck;
   logic spi_cs_n;
   logic spi_si;
   logic spi_so;
   logic spi_so_oe;
   fsra_stat_t status_out;
   fsra_stat_t m;
   logic vg;
   int fails;
   int checks_done;
   logic [7:0] ops [6] = '{8'h06, 8'h50, 8'h01, 8'h31, 8'h11, 8'h71};
   fsra_top uut (.clk_sys(clk_sys), .rst(rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
      .spi_si(spi_si), .spi_so(spi_so), .spi_so_oe(spi_so_oe), .status_out(status_out));
   fsra_host_model host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
      .spi_so(spi_so), .spi_so_oe(spi_so_oe));
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // ****
   // Expected state of the status bytes
   // ****
   function automatic void apply(input logic [7:0] b[$], input int nbits);
      int nb;
      logic ok;
      logic en;
      nb = nbits / 8;
      ok = 1'b0;
      en = m[0][1] | vg;
      if (nbits % 8 != 0 || nb == 0) return;
      case (b[0])
         8'h06: if (nb == 1) m[0][1] = 1'b1;
         8'h50: if (nb == 1) vg = 1'b1;
         8'h01: ok = (nb == 2 || nb == 3);
         8'h31, 8'h11: ok = (nb == 2);
         8'h71: begin
            ok = (nb == 3 && b[1] >= 8'h01 && b[1] <= 8'h06);
            if (nb == 3 && !ok) m[0][1] = 1'b0;
         end
         default: ;
      endcase
      if (ok && en) begin
         case (b[0])
            8'h01: begin
               m[0] = b[1];
               if (nb == 3) m[1] = b[2];
            end
            8'h31: m[1] = b[1];
            8'h11: m[2] = b[1];
            default: m[b[1][2:0] - 3'h1] = b[2];
         endcase
         m[0][1] = 1'b0;
      end
      if (b[0] inside {8'h01, 8'h31, 8'h11, 8'h71}) vg = 1'b0;
   endfunction
   function automatic logic [7:0] rd_exp(input logic [7:0] a);
      return (a >= 8'h01 && a <= 8'h06) ? m[a[2:0] - 3'h1] : 8'h00;
   endfunction
   task automatic end_of_test();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Gap after each frame lets the commit land before the next one starts
   task automatic frame(input logic [7:0] b[$], input int nbits, input int nrd);
      int i;
      host.xfer(b, nbits, nrd);
      apply(b, nbits);
      repeat (8) @(negedge clk_sys);
      `CHK("spi_so_oe", 1'b0, spi_so_oe)
      `CHK("status_out", m, status_out)
      for (i = 0; i < nrd; i++) begin
         `CHK("read byte", rd_exp(b[1] + 8'(i)), host.rx[i])
      end
   endtask
   // ****
   // Scenarios
   // ****
   initial begin
      int k;
      logic [7:0] d;
      logic [7:0] op;
      fails = 0;
      checks_done = 0;
      m = '0;
      vg = 1'b0;
      rst = 1'b1;
      void'($urandom(32'h63fd6860));
      repeat (8) @(negedge clk_sys);
      rst = 1'b0;
      repeat (4) @(negedge clk_sys);
      `CHK("reset status", 48'h0, status_out)
      d = 8'($urandom());
      frame({8'h71, 8'h02, d}, 24, 0);
      for (k = 1; k <= 6; k++) begin
         d = 8'($urandom());
         frame({8'h06}, 8, 0);
         frame({8'h71, 8'(k), d}, 24, 0);
      end
      for (k = 2; k <= 4; k++) begin
         d = 8'($urandom());
         frame({8'h06}, 8, 0);
         frame({ops[k], d}, 16, 0);
      end
      frame({8'h06}, 8, 0);
      frame({8'h01, d, ~d}, 24, 0);
      frame({8'h50}, 8, 0);
      frame({8'h31, d}, 16, 0);
      frame({8'h11, ~d}, 16, 0);
      frame({8'h06}, 8, 0);
      frame({8'h71, 8'h03, d, d}, 32, 0);
      frame({8'h71, 8'h07, d}, 24, 0);
      frame({8'h06}, 8, 0);
      frame({8'h01, d}, 13, 0);
      frame({8'h71, 8'h00, d}, 24, 0);
      frame({8'h65, 8'h01, 8'h00}, 24, 7);
      frame({8'h65, 8'h05, 8'h00}, 24, 260);
      frame({8'h65, 8'h03, 8'h00, 8'h00}, 29, 0);
      for (k = 0; k < 30; k++) begin
         op = ops[$urandom_range(5)];
         d = 8'($urandom());
         case (op)
            8'h06, 8'h50: frame({op}, 8, 0);
            8'h71: frame({op, 8'($urandom_range(7)), d}, 24, 0);
            8'h01: frame({op, d, ~d}, 16 + 8 * $urandom_range(1), 0);
            default: frame({op, d}, 16, 0);
         endcase
         frame({8'h65, 8'($urandom()), 8'h00}, 24, 2);
      end
      end_of_test();
   end
endmodule
`default_nettype wire
